// ===== adc_seq_checker_assertions.sv
`timescale 1ns/1ps
module adc_seq_checker #(
	parameter NUM_PIN = 9
) (
	input logic                 mclk,
	input logic                 reset_n,
	input logic                 ce,
	input logic                 psel,
	input logic                 penable,
	input logic                 pwrite,
	input logic [11:0]          paddr,
	input logic [31:0]          pwdata,
	input logic [31:0]          prdata,
	input logic                 pready,
	input logic                 pslverr,
	input logic [NUM_PIN-1:0]   pinAnalogSel,
	input logic [NUM_PIN-1:0]   pinDigitalOff,
	input logic [NUM_PIN-1:0]   pullHighOff,
	input logic                 extConnect,
	input logic [3:0]           extChannel,
	input logic [2:0]           internalSource
);
	// ----------------------------------------------------------------
	// bus and source-selection checks
	// ----------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// an access phase that has not been answered yet
	sequence waiting;
		psel && penable && !pready && ce;
	endsequence
	sequence srcWrite;
		psel && penable && pready && pwrite && paddr == 12'h00C;
	endsequence

	// decoded internal source captured at the write edge; 0 for external or ground
	logic [2:0] expSrc_ff;
	wire  [3:0] srcCode = pwdata[7:4];
	always @(posedge mclk or negedge reset_n)
		if (!reset_n)
			expSrc_ff <= 3'h0;
		else if (psel && penable && pready && pwrite && paddr == 12'h00C)
			expSrc_ff <= (!srcCode[3] && srcCode[1:0] != 2'h0) ? srcCode[2:0] : 3'h0;

	AST_ONE_WAIT: assert property (waiting |=> pready)
		else $error("access not answered after one wait state");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready stood longer than one cycle");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready && psel && penable)
		else $error("error flag outside an answered access");
	AST_UNMAPPED: assert property (pready && !pwrite && (paddr[1:0] != 2'h0
		|| paddr > 12'h01C) |-> pslverr && prdata == 32'h0)
		else $error("unmapped read not refused");
	AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	AST_PIN_RELEASE: assert property ($past(reset_n) |->
		pinDigitalOff == $past(pinAnalogSel) && pullHighOff == $past(pinAnalogSel))
		else $error("analog pin did not drop digital function or pull-high");
	AST_INT_OFF: assert property (internalSource != 3'h0 |-> !extConnect)
		else $error("external channel connected with internal source");
	AST_CHAN_OK: assert property (extConnect |-> extChannel <= 4'h8 && extChannel != 4'h2)
		else $error("external channel connected for a non-routed code");
	AST_SRC_DECODE: assert property (srcWrite |-> ##[1:3] internalSource == expSrc_ff)
		else $error("internal source output does not match written code");
endmodule

bind adc_sequencer_regs adc_seq_checker #(.NUM_PIN(NUM_PIN)) chk (.mclk(mclk),
	.reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pinAnalogSel(pinAnalogSel), .pinDigitalOff(pinDigitalOff), .pullHighOff(pullHighOff),
	.extConnect(extConnect), .extChannel(extChannel), .internalSource(internalSource));

// ===== adc_seq_map.vh
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

// ----------------------------------------------------------------
// register byte offsets on the bus
// ----------------------------------------------------------------
`define OFS_RESULT_LOW      12'h000
`define OFS_RESULT_HIGH     12'h004
`define OFS_CTRL_MAIN       12'h008
`define OFS_SRC_CLOCK       12'h00C
`define OFS_REF_GAIN        12'h010
`define OFS_BANDGAP         12'h014
`define OFS_IRQ_STATUS      12'h018
`define OFS_IRQ_MASK        12'h01C

// ----------------------------------------------------------------
// conv_control_main fields
// ----------------------------------------------------------------
`define CM_START_BIT        7
`define CM_BUSY_BIT         6
`define CM_ENABLE_BIT       5
`define CM_JUSTIFY_BIT      4
`define CM_CHAN_MSB         3
`define CM_CHAN_LSB         0

// ----------------------------------------------------------------
// conv_source_clock fields
// ----------------------------------------------------------------
`define SC_SRC_MSB          7
`define SC_SRC_LSB          4
`define SC_DIV_MSB          2
`define SC_DIV_LSB          0

// ----------------------------------------------------------------
// conv_reference_gain and bandgap_control fields
// ----------------------------------------------------------------
`define RG_AMP_EN_BIT       7
`define RG_AMP_IN_BIT       4
`define RG_REF_MSB          3
`define RG_REF_LSB          2
`define RG_GAIN_MSB         1
`define RG_GAIN_LSB         0
`define BG_ENABLE_BIT       0

// ----------------------------------------------------------------
// interrupt status / mask fields
// ----------------------------------------------------------------
`define IRQ_DONE_BIT        0
`define IRQ_REFUSED_BIT     1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CTRL_MAIN       8'h00
`define RST_SRC_CLOCK       8'h00
`define RST_REF_GAIN        8'h00
`define RST_BANDGAP         8'h00
`define RST_IRQ_MASK        2'h0

// ----------------------------------------------------------------
// conversion timing, in conversion clock ticks
// ----------------------------------------------------------------
`define SAMPLE_TICKS        4'h4

`endif

// ===== adc_sequencer_regs.v
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "adc_seq_map.vh"

module adc_sequencer_regs #(
	parameter RES     = 12,
	parameter NUM_PIN = 9
) (
	input  wire                 mclk,
	input  wire                 reset_n,
	input  wire                 ce,
	input  wire                 psel,
	input  wire                 penable,
	input  wire                 pwrite,
	input  wire [11:0]          paddr,
	input  wire [31:0]          pwdata,
	output reg  [31:0]          prdata,
	output reg                  pready,
	output reg                  pslverr,
	output reg                  irq,
	input  wire                 cmpHigh,
	input  wire [NUM_PIN-1:0]   pinAnalogSel,
	output reg  [NUM_PIN-1:0]   pinDigitalOff,
	output reg  [NUM_PIN-1:0]   pullHighOff,
	output wire [RES-1:0]       sarTrial,
	output wire                 sampleHold,
	output reg                  converterPowerOn,
	output reg                  extConnect,
	output reg  [3:0]           extChannel,
	output reg  [2:0]           internalSource,
	output wire                 gainAmpEnable,
	output wire                 gainAmpInputSel,
	output wire [1:0]           referenceSelect,
	output wire [1:0]           gainSelect,
	output wire                 bandgapEnable
);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------

	// external source codes 0000, 0100 and 1100..1111
	function srcIsExternal;
		input [3:0] code;
		begin
			srcIsExternal = (code == 4'h0) || (code == 4'h4) || (code[3:2] == 2'h3);
		end
	endfunction

	// channels that exist: 0, 1 and 3..8
	function chanExists;
		input [3:0] code;
		begin
			chanExists = (code == 4'h0) || (code == 4'h1)
				|| ((code >= 4'h3) && (code <= 4'h8));
		end
	endfunction

	// internal node: 1..3 supply fractions, 5..7 amplifier fractions, 0 ground
	function [2:0] internalCode;
		input [3:0] code;
		begin
			if (code[3])
				internalCode = 3'h0;
			else
				internalCode = code[2:0];
		end
	endfunction

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	reg                 start_ff;
	reg                 enable_ff;
	reg                 justify_ff;
	reg  [3:0]          chanSel_ff;
	reg  [3:0]          srcSel_ff;
	reg  [2:0]          divSel_ff;
	reg  [7:0]          refGain_ff;
	reg                 bandgap_ff;
	reg  [1:0]          irqStatus_ff;
	reg  [1:0]          irqMask_ff;
	reg                 startReq_ff;

	// full reset byte kept so the source field can be sliced out at its own width
	localparam [7:0]    RST_SRC_BYTE = `RST_SRC_CLOCK;

	wire                convTick;
	wire                busy;
	wire                convDone;
	wire [RES-1:0]      result;

	wire                access;
	wire                doWrite;
	wire                doRead;
	wire                mapped;
	wire                startFall;
	wire [7:0]          wByte;
	reg  [7:0]          rdByte;
	wire [15:0]         justified;

	assign access  = psel & penable & pready;
	assign doWrite = access & pwrite;
	assign doRead  = access & ~pwrite;
	assign wByte   = pwdata[7:0];
	assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= `OFS_IRQ_MASK);

	// start bit written from one back to zero completes the pulse
	assign startFall = doWrite && (paddr == `OFS_CTRL_MAIN) && start_ff
		&& !wByte[`CM_START_BIT];

	// ----------------------------------------------------------------
	// conversion engine
	// ----------------------------------------------------------------
	conv_clock_divider u_div (
		.mclk    (mclk),
		.reset_n (reset_n),
		.ce      (ce),
		.run     (busy),
		.divSel  (divSel_ff),
		.tick_ff (convTick)
	);

	sar_approx #(
		.RES (RES)
	) u_sar (
		.mclk        (mclk),
		.reset_n     (reset_n),
		.ce          (ce),
		.start       (startReq_ff),
		.abort       (~enable_ff),
		.tick        (convTick),
		.cmpHigh     (cmpHigh),
		.trial_ff    (sarTrial),
		.sampling_ff (sampleHold),
		.busy_ff     (busy),
		.done_ff     (convDone),
		.result_ff   (result)
	);

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------

	// control writes; busy has no storage here so writes to it vanish
	always @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			start_ff    <= 1'b0;
			enable_ff   <= 1'b0;
			justify_ff  <= 1'b0;
			chanSel_ff  <= 4'h0;
			srcSel_ff   <= RST_SRC_BYTE[`SC_SRC_MSB:`SC_SRC_LSB];
			divSel_ff   <= RST_SRC_BYTE[`SC_DIV_MSB:`SC_DIV_LSB];
			refGain_ff  <= `RST_REF_GAIN;
			bandgap_ff  <= 1'b0;
			irqMask_ff  <= `RST_IRQ_MASK;
			startReq_ff <= 1'b0;
		end
		else if (ce)
		begin
			// a start only counts with the converter on and idle
			startReq_ff <= startFall && enable_ff && !busy;
			if (doWrite)
			begin
				case (paddr)
					`OFS_CTRL_MAIN:
					begin
						start_ff   <= wByte[`CM_START_BIT];
						enable_ff  <= wByte[`CM_ENABLE_BIT];
						justify_ff <= wByte[`CM_JUSTIFY_BIT];
						chanSel_ff <= wByte[`CM_CHAN_MSB:`CM_CHAN_LSB];
					end
					`OFS_SRC_CLOCK:
					begin
						srcSel_ff <= wByte[`SC_SRC_MSB:`SC_SRC_LSB];
						divSel_ff <= wByte[`SC_DIV_MSB:`SC_DIV_LSB];
					end
					`OFS_REF_GAIN:
					begin
						// bits 6 and 5 are not kept
						refGain_ff <= wByte & 8'h9F;
					end
					`OFS_BANDGAP:
					begin
						bandgap_ff <= wByte[`BG_ENABLE_BIT];
					end
					`OFS_IRQ_MASK:
					begin
						irqMask_ff <= wByte[1:0];
					end
					default:
					begin
						bandgap_ff <= bandgap_ff;
					end
				endcase
			end
		end
	end

	assign gainAmpEnable   = refGain_ff[`RG_AMP_EN_BIT];
	assign gainAmpInputSel = refGain_ff[`RG_AMP_IN_BIT];
	assign referenceSelect = refGain_ff[`RG_REF_MSB:`RG_REF_LSB];
	assign gainSelect      = refGain_ff[`RG_GAIN_MSB:`RG_GAIN_LSB];
	assign bandgapEnable   = bandgap_ff;

	// ----------------------------------------------------------------
	// interrupt status
	// ----------------------------------------------------------------

	// write one to clear; a new event in the same cycle wins over the clear
	always @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irqStatus_ff <= 2'h0;
			irq          <= 1'b0;
		end
		else if (ce)
		begin
			irqStatus_ff <= (irqStatus_ff
				& ~((doWrite && (paddr == `OFS_IRQ_STATUS)) ? wByte[1:0] : 2'h0))
				| {startFall && !enable_ff, convDone};
			irq <= |(irqStatus_ff & irqMask_ff);
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------

	// result is formatted on read so both bytes always come from one word
	assign justified = justify_ff ? {4'h0, result} : {result, 4'h0};

	always @*
	begin
		case (paddr)
			`OFS_RESULT_LOW:  rdByte = justified[7:0];
			`OFS_RESULT_HIGH: rdByte = justified[15:8];
			`OFS_CTRL_MAIN:   rdByte = {start_ff, busy, enable_ff, justify_ff, chanSel_ff};
			`OFS_SRC_CLOCK:   rdByte = {srcSel_ff, 1'b0, divSel_ff};
			`OFS_REF_GAIN:    rdByte = refGain_ff;
			`OFS_BANDGAP:     rdByte = {7'h00, bandgap_ff};
			`OFS_IRQ_STATUS:  rdByte = {6'h00, irqStatus_ff};
			`OFS_IRQ_MASK:    rdByte = {6'h00, irqMask_ff};
			default:          rdByte = 8'h00;
		endcase
	end

	// one wait state: pready rises in the second access cycle, data registered with it
	always @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (ce)
		begin
			if (psel && penable && !pready)
			begin
				pready  <= 1'b1;
				pslverr <= !mapped;
				prdata  <= (!pwrite && mapped) ? {24'h000000, rdByte} : 32'h00000000;
			end
			else
			begin
				pready  <= 1'b0;
				pslverr <= 1'b0;
				if (doRead)
					prdata <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------------------------------
	// analog routing
	// ----------------------------------------------------------------

	// internal source forces the external switch open; floating codes close nothing
	always @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			converterPowerOn <= 1'b0;
			extConnect       <= 1'b0;
			extChannel       <= 4'h0;
			internalSource   <= 3'h0;
			pinDigitalOff    <= {NUM_PIN{1'b0}};
			pullHighOff      <= {NUM_PIN{1'b0}};
		end
		else if (ce)
		begin
			converterPowerOn <= enable_ff;
			extConnect       <= enable_ff && srcIsExternal(srcSel_ff)
				&& chanExists(chanSel_ff);
			extChannel       <= chanSel_ff;
			internalSource   <= srcIsExternal(srcSel_ff) ? 3'h0 : internalCode(srcSel_ff);
			pinDigitalOff    <= pinAnalogSel;
			pullHighOff      <= pinAnalogSel;
		end
	end

endmodule

// ===== conv_clock_divider.v
`timescale 1ns/1ps
`include "adc_seq_map.vh"

module conv_clock_divider #(
	parameter CNT_W = 7
) (
	input  wire             mclk,
	input  wire             reset_n,
	input  wire             ce,
	input  wire             run,
	input  wire [2:0]       divSel,
	output reg              tick_ff
);

	reg  [CNT_W-1:0] count_ff;
	wire [CNT_W-1:0] limit;

	// terminal count is 2^divSel - 1, so 000 ticks every cycle
	assign limit = {CNT_W{1'b1}} >> (3'h7 - divSel);

	// counter restarts whenever the converter is idle so every run has the same phase
	always @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count_ff <= {CNT_W{1'b0}};
			tick_ff  <= 1'b0;
		end
		else if (ce)
		begin
			if (!run)
			begin
				count_ff <= {CNT_W{1'b0}};
				tick_ff  <= 1'b0;
			end
			else if (count_ff >= limit)
			begin
				count_ff <= {CNT_W{1'b0}};
				tick_ff  <= 1'b1;
			end
			else
			begin
				count_ff <= count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
				tick_ff  <= 1'b0;
			end
		end
	end

endmodule

// ===== sar_approx.v
`timescale 1ns/1ps
`include "adc_seq_map.vh"

module sar_approx #(
	parameter RES = 12
) (
	input  wire             mclk,
	input  wire             reset_n,
	input  wire             ce,
	input  wire             start,
	input  wire             abort,
	input  wire             tick,
	input  wire             cmpHigh,
	output reg  [RES-1:0]   trial_ff,
	output reg              sampling_ff,
	output reg              busy_ff,
	output reg              done_ff,
	output reg  [RES-1:0]   result_ff
);

	localparam [1:0] ST_IDLE   = 2'h0;
	localparam [1:0] ST_SAMPLE = 2'h1;
	localparam [1:0] ST_CONV   = 2'h2;

	reg [1:0]     state_ff;
	reg [3:0]     cnt_ff;
	reg [RES-1:0] bitMask_ff;

	// one decision per tick, msb first; comparator high keeps the trial bit
	always @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_ff    <= ST_IDLE;
			cnt_ff      <= 4'h0;
			bitMask_ff  <= {RES{1'b0}};
			trial_ff    <= {RES{1'b0}};
			sampling_ff <= 1'b0;
			busy_ff     <= 1'b0;
			done_ff     <= 1'b0;
			result_ff   <= {RES{1'b0}};
		end
		else if (ce)
		begin
			done_ff <= 1'b0;
			if (abort)
			begin
				// disabling mid-run drops the result, old data stays put
				state_ff    <= ST_IDLE;
				sampling_ff <= 1'b0;
				busy_ff     <= 1'b0;
				trial_ff    <= {RES{1'b0}};
			end
			else
			begin
				case (state_ff)
					ST_IDLE:
					begin
						if (start)
						begin
							state_ff    <= ST_SAMPLE;
							cnt_ff      <= 4'h0;
							sampling_ff <= 1'b1;
							busy_ff     <= 1'b1;
						end
					end
					ST_SAMPLE:
					begin
						if (tick)
						begin
							if (cnt_ff == `SAMPLE_TICKS - 4'h1)
							begin
								state_ff    <= ST_CONV;
								sampling_ff <= 1'b0;
								bitMask_ff  <= {1'b1, {(RES-1){1'b0}}};
								trial_ff    <= {1'b1, {(RES-1){1'b0}}};
							end
							cnt_ff <= cnt_ff + 4'h1;
						end
					end
					ST_CONV:
					begin
						if (tick)
						begin
							if (bitMask_ff[0])
							begin
								// full word lands with busy falling, never a partial value
								result_ff <= cmpHigh ? trial_ff : (trial_ff & ~bitMask_ff);
								busy_ff   <= 1'b0;
								done_ff   <= 1'b1;
								trial_ff  <= {RES{1'b0}};
								state_ff  <= ST_IDLE;
							end
							else
							begin
								trial_ff <= (cmpHigh ? trial_ff : (trial_ff & ~bitMask_ff))
									| (bitMask_ff >> 1);
								bitMask_ff <= bitMask_ff >> 1;
							end
						end
					end
					default:
					begin
						state_ff <= ST_IDLE;
						busy_ff  <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
	note_t          q[$];
	logic           mclk = '0;
	logic           reset_n = '0;
	logic           psel = '0;
	logic           penable = '0;
	logic           pwrite = '0;
	logic [11:0]    paddr = '0;
	logic [31:0]    pwdata = '0;
	logic [8:0]     pinAnalogSel = '0;
	logic [11:0]    level = '0;
	logic [31:0]    rd;
	logic [11:0]    v;
	logic [3:0]     ch;
	logic [11:0]    ofs [6] = '{12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C};
	wire  [31:0]    prdata;
	wire            pready;
	wire            pslverr;
	wire            irq;
	wire  [11:0]    sarTrial;
	wire            powerOn;
	wire            ampEn;
	wire            ampIn;
	wire  [1:0]     refSel;
	wire  [1:0]     gainSel;
	wire            bgEn;
	int             n_errors = 0;
	int             cmp_count = 0;
	int             cyc = 0;

	// comparator model: SAR settles on the largest code not above level
	wire            cmpHigh = level >= sarTrial;

	adc_sequencer_regs dut (.mclk(mclk), .reset_n(reset_n), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .cmpHigh(cmpHigh),
		.pinAnalogSel(pinAnalogSel), .pinDigitalOff(), .pullHighOff(), .sarTrial(sarTrial),
		.sampleHold(), .converterPowerOn(powerOn), .extConnect(), .extChannel(),
		.internalSource(), .gainAmpEnable(ampEn), .gainAmpInputSel(ampIn),
		.referenceSelect(refSel), .gainSelect(gainSel), .bandgapEnable(bgEn));

	always #2 mclk = ~mclk;

	// ----------------------------------------------------------------
	// checking and bus tasks
	// ----------------------------------------------------------------
	task automatic fail(input string s);
		n_errors++;
		$display("unexpected at %0t: %s", $time, s);
	endtask
	task automatic chkBus(input note_t n);
		cmp_count++;
		if (pslverr !== n.e || (prdata & n.m) !== (n.d & n.m))
			fail($sformatf("bus got %h/%b exp %h/%b", prdata, pslverr, n.d, n.e));
	endtask
	task automatic chkFlag(input logic ok, input string s);
		cmp_count++;
		if (ok !== 1'b1)
			fail(s);
	endtask
	// irq is registered one cycle behind status and mask
	task automatic chkIrq(input logic e);
		@(posedge mclk);
		#1;
		chkFlag(irq === e, "irq level");
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// monitor: every answered transfer retires the oldest note
	always @(posedge mclk)
		if (pready && q.size() > 0)
			chkBus(q.pop_front());

	// a hang ends the run as a mismatch
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			fail("timeout");
			wrap_up();
		end
	end

	// request held untouched until pready is sampled high
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] ed, input logic [31:0] em, input logic ee);
		q.push_back('{ed, em, ee});
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d}, 32'h0, 32'h0, 1'b0);
	endtask
	task automatic rdx(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		bus(1'b0, a, 32'h0, e, m, 1'b0);
	endtask

	// one full conversion against a random level, then status and irq handling
	task automatic convert(input logic [2:0] dv, input logic j, input logic [3:0] src);
		int t0;
		v = 12'($urandom);
		ch = 4'($urandom);
		if (ch == 4'h2 || (ch > 4'h8 && ch < 4'hC))
			ch = 4'hC;
		level <= v;
		pinAnalogSel <= 9'($urandom);
		wr(12'h00C, {src, 1'b0, dv});
		wr(12'h008, {3'h5, j, ch});
		wr(12'h008, {3'h1, j, ch});
		t0 = cyc;
		rdx(12'h008, 32'h60, 32'h60);
		while (rd[6])
			rdx(12'h008, 32'h0, 32'h0);
		chkFlag(cyc - t0 >= (32'hF << dv) && cyc - t0 <= (32'h11 << dv) + 32'hC, "duration");
		rdx(12'h004, j ? {28'h0, v[11:8]} : {24'h0, v[11:4]}, ~32'h0);
		rdx(12'h000, j ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0}, ~32'h0);
		rdx(12'h018, 32'h1, ~32'h0);
		chkIrq(1'b1);
		wr(12'h018, 8'h01);
		chkIrq(1'b0);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h70013E8C));
		repeat (8) @(posedge mclk);
		chkIrq(1'b0);
		reset_n <= 1'b1;
		foreach (ofs[i])
			rdx(ofs[i], 32'h0, ~32'h0);
		wr(12'h008, 8'h5F);
		rdx(12'h008, 32'h1F, ~32'h0);
		wr(12'h00C, 8'hFF);
		rdx(12'h00C, 32'hF7, ~32'h0);
		wr(12'h010, 8'hFF);
		rdx(12'h010, 32'h9F, ~32'h0);
		chkFlag(ampEn && ampIn && refSel == 2'h3 && gainSel == 2'h3, "gain outputs");
		wr(12'h014, 8'hFF);
		rdx(12'h014, 32'h01, ~32'h0);
		chkFlag(bgEn === 1'b1, "bandgap output");
		bus(1'b0, 12'h020, 32'h0, 32'h0, ~32'h0, 1'b1);
		bus(1'b1, 12'h02C, 32'h5, 32'h0, 32'h0, 1'b1);
		bus(1'b0, 12'h009, 32'h0, 32'h0, ~32'h0, 1'b1);
		$display("test registers done");
		wr(12'h01C, 8'h03);
		wr(12'h008, 8'h80);
		wr(12'h008, 8'h00);
		rdx(12'h008, 32'h0, ~32'h0);
		rdx(12'h018, 32'h2, ~32'h0);
		chkIrq(1'b1);
		wr(12'h01C, 8'h01);
		chkIrq(1'b0);
		wr(12'h018, 8'h02);
		rdx(12'h018, 32'h0, ~32'h0);
		$display("test refused start done");
		for (int s = 0; s < 16; s++)
			wr(12'h00C, {4'(s), 4'h0});
		for (int i = 0; i < 8; i++)
			convert(3'(i), i[0], {3'(i), i[0]});
		$display("test conversions done");
		wr(12'h00C, 8'h07);
		wr(12'h008, 8'hA0);
		wr(12'h008, 8'h20);
		level <= ~v;
		rdx(12'h008, 32'h60, ~32'h0);
		chkFlag(powerOn === 1'b1, "converter power on");
		wr(12'h008, 8'h00);
		rdx(12'h008, 32'h0, ~32'h0);
		chkFlag(powerOn === 1'b0, "converter power off");
		rdx(12'h004, {24'h0, v[11:4]}, ~32'h0);
		rdx(12'h000, {24'h0, v[3:0], 4'h0}, ~32'h0);
		$display("test abort done");
		wrap_up();
	end
endmodule
